// File: rtl/dual_timer_counter_control.sv
// Dual 8-bit-pair timer/counter with external interrupt flags, reached over APB.
`timescale 1ns/10ps
`default_nettype none

module dual_timer_counter_control
	import timer_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire apb_req_t apb_req,
	output apb_rsp_t apb_rsp,
	// Pins from outside, asynchronous
	input wire ext_pins_t pins,
	// Interrupt controller side
	input wire irq_lines_t irq_ack,
	output irq_lines_t irq_req,
	output logic irq
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] mode;
		logic [7:0] tl0;
		logic [7:0] th0;
		logic [7:0] tl1;
		logic [7:0] th1;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [1:0] ext_prev;
		logic [1:0] pin_prev;
		logic [3:0] prescale;
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		logic irq;
	} state_t;

	localparam logic [3:0] PRESCALE_END = 4'(PERIPH_DIV - 1);
	localparam logic [2:0] SEL_NONE = 3'h7;

	state_t st_r;
	state_t st_nxt;

	// Maps a byte address to a register select; SEL_NONE for unmapped.
	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
		logic [2:0] s;
		s = SEL_NONE;
		if (a[1:0] == 2'b00) begin
			case (a[ADDR_W-1:2])
				10'(IDX_TIMER_CONTROL): s = 3'h0;
				10'(IDX_TIMER_MODE): s = 3'h1;
				10'(IDX_TIMER0_COUNT_LOW): s = 3'h2;
				10'(IDX_TIMER0_COUNT_HIGH): s = 3'h3;
				10'(IDX_TIMER1_COUNT_LOW): s = 3'h4;
				10'(IDX_TIMER1_COUNT_HIGH): s = 3'h5;
				10'(IDX_IRQ_STATUS): s = 3'h6;
				10'(IDX_IRQ_MASK): s = 3'h6;
				default: s = SEL_NONE;
			endcase
		end
		return s;
	endfunction : reg_sel

	// One counting step of a timer pair; result is {overflow, high, low}.
	// Mode 11 is treated as a lone 8-bit low byte; the caller blocks it for a halted timer.
	function automatic logic [16:0] step_timer(input logic [1:0] m, input logic [7:0] tl,
			input logic [7:0] th, input logic inc);
		logic ovf;
		logic [7:0] l;
		logic [7:0] h;
		ovf = 1'b0;
		l = tl;
		h = th;
		if (inc) begin
			case (timer_mode_t'(m))
				MODE_PRESCALED: begin
					// The upper three low-byte bits are left alone.
					if (tl[4:0] == PRESCALE_LAST) begin
						l[4:0] = 5'h00;
						h = th + 8'h01;
						ovf = (th == 8'hff);
					end else begin
						l[4:0] = tl[4:0] + 5'h01;
					end
				end
				MODE_16BIT: begin
					{ovf, h, l} = {1'b0, th, tl} + 17'h00001;
				end
				MODE_AUTO_RELOAD: begin
					if (tl == 8'hff) begin
						l = th;
						ovf = 1'b1;
					end else begin
						l = tl + 8'h01;
					end
				end
				MODE_SPLIT_HALT: begin
					{ovf, l} = {1'b0, tl} + 9'h001;
				end
				default: begin
					ovf = 1'b0;
				end
			endcase
		end
		return {ovf, h, l};
	endfunction : step_timer

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		logic tick;
		logic t0_pin;
		logic t1_pin;
		logic ext_irq0_n_n;
		logic ext_irq1_n_n;
		logic [1:0] t0_mode;
		logic [1:0] t1_mode;
		logic t0_en;
		logic t1_en;
		logic t0_inc;
		logic t1_inc;
		logic run1_eff;
		logic t0_split;
		logic t1_halt;
		logic [16:0] r0;
		logic [16:0] r1;
		logic th0_ovf;
		logic [8:0] th0_sum;
		logic [1:0] ext_set;
		logic [3:0] evt;
		logic setup;
		logic wr;
		logic wr_lane;
		logic [2:0] sel;
		logic [7:0] wd;
		logic [7:0] hw_set;
		logic [7:0] hw_clr;

		st_nxt = st_r;
		tick = (st_r.prescale == PRESCALE_END);
		t0_pin = st_r.sync2[0];
		t1_pin = st_r.sync2[1];
		ext_irq0_n_n = st_r.sync2[2];
		ext_irq1_n_n = st_r.sync2[3];
		hw_set = 8'h00;
		hw_clr = 8'h00;
		t0_mode = st_r.mode[MOD_TIMER0_MODE_HI:MOD_TIMER0_MODE_LO];
		t1_mode = st_r.mode[MOD_TIMER1_MODE_HI:MOD_TIMER1_MODE_LO];
		t0_en = 1'b0;
		t1_en = 1'b0;
		t0_inc = 1'b0;
		t1_inc = 1'b0;
		run1_eff = 1'b0;
		t0_split = 1'b0;
		t1_halt = 1'b0;
		r0 = '0;
		r1 = '0;
		th0_ovf = 1'b0;
		th0_sum = '0;
		ext_set = 2'b00;
		evt = 4'h0;
		setup = 1'b0;
		wr = 1'b0;
		wr_lane = 1'b0;
		sel = SEL_NONE;
		wd = 8'h00;

		// Pins pass two flip-flops before anything looks at them.
		st_nxt.sync1 = pins;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.prescale = tick ? 4'h0 : st_r.prescale + 4'h1;

		// Count pins are sampled once per peripheral cycle, so a fall needs two samples.
		if (tick) begin
			st_nxt.pin_prev = {t1_pin, t0_pin};
		end

		t0_split = (t0_mode == MODE_SPLIT_HALT);
		t1_halt = (t1_mode == MODE_SPLIT_HALT);
		// While timer 0 is split, its high byte owns the timer 1 run bit and timer 1
		// is switched only by entering and leaving its halt mode and, with gating set, by its pin.
		run1_eff = t0_split ? 1'b1 : st_r.ctrl[CTL_TIMER1_RUN];

		t0_en = st_r.ctrl[CTL_TIMER0_RUN] && (!st_r.mode[MOD_TIMER0_PIN_GATING] || ext_irq0_n_n);
		t1_en = run1_eff && (!st_r.mode[MOD_TIMER1_PIN_GATING] || ext_irq1_n_n) && !t1_halt;

		// A counter source only advances on a tick, so a pin level shorter than a tick can be missed.
		if (st_r.mode[MOD_TIMER0_COUNT_SOURCE_SEL]) begin
			t0_inc = t0_en && tick && st_r.pin_prev[0] && !t0_pin;
		end else begin
			t0_inc = t0_en && tick;
		end
		if (st_r.mode[MOD_TIMER1_COUNT_SOURCE_SEL]) begin
			t1_inc = t1_en && tick && st_r.pin_prev[1] && !t1_pin;
		end else begin
			t1_inc = t1_en && tick;
		end

		r0 = step_timer(t0_mode, st_r.tl0, st_r.th0, t0_inc);
		r1 = step_timer(t1_mode, st_r.tl1, st_r.th1, t1_inc);
		st_nxt.tl0 = r0[7:0];
		st_nxt.th0 = r0[15:8];
		st_nxt.tl1 = r1[7:0];
		st_nxt.th1 = r1[15:8];

		// Split high byte: always a timer on peripheral ticks, run by timer 1's bit.
		th0_ovf = 1'b0;
		th0_sum = {1'b0, st_r.th0} + 9'h001;
		if (t0_split && tick && st_r.ctrl[CTL_TIMER1_RUN]) begin
			st_nxt.th0 = th0_sum[7:0];
			th0_ovf = th0_sum[8];
		end

		hw_set[CTL_TIMER0_OVERFLOW_FLAG] = r0[16];
		// Timer 1 gives up its flag to the split high byte.
		hw_set[CTL_TIMER1_OVERFLOW_FLAG] = t0_split ? th0_ovf : r1[16];

		// External interrupts: falling edge latches, low level follows the pin.
		st_nxt.ext_prev = {ext_irq1_n_n, ext_irq0_n_n};
		if (st_r.ctrl[CTL_EXT_IRQ0_EDGE_SEL]) begin
			ext_set[0] = st_r.ext_prev[0] && !ext_irq0_n_n;
		end else begin
			ext_set[0] = !ext_irq0_n_n;
		end
		if (st_r.ctrl[CTL_EXT_IRQ1_EDGE_SEL]) begin
			ext_set[1] = st_r.ext_prev[1] && !ext_irq1_n_n;
		end else begin
			ext_set[1] = !ext_irq1_n_n;
		end
		hw_set[CTL_EXT_IRQ0_FLAG] = ext_set[0];
		hw_set[CTL_EXT_IRQ1_FLAG] = ext_set[1];
		if (!st_r.ctrl[CTL_EXT_IRQ0_EDGE_SEL]) begin
			hw_clr[CTL_EXT_IRQ0_FLAG] = ext_irq0_n_n;
		end
		if (!st_r.ctrl[CTL_EXT_IRQ1_EDGE_SEL]) begin
			hw_clr[CTL_EXT_IRQ1_FLAG] = ext_irq1_n_n;
		end

		// Acknowledge clears; external flags only when edge triggered.
		hw_clr[CTL_TIMER0_OVERFLOW_FLAG] = irq_ack.timer0_overflow;
		hw_clr[CTL_TIMER1_OVERFLOW_FLAG] = irq_ack.timer1_overflow;
		if (st_r.ctrl[CTL_EXT_IRQ0_EDGE_SEL] && irq_ack.ext_irq0) begin
			hw_clr[CTL_EXT_IRQ0_FLAG] = 1'b1;
		end
		if (st_r.ctrl[CTL_EXT_IRQ1_EDGE_SEL] && irq_ack.ext_irq1) begin
			hw_clr[CTL_EXT_IRQ1_FLAG] = 1'b1;
		end

		evt = {hw_set[CTL_TIMER1_OVERFLOW_FLAG], hw_set[CTL_TIMER0_OVERFLOW_FLAG],
			ext_set[1] && !st_r.ctrl[CTL_EXT_IRQ1_FLAG], ext_set[0] && !st_r.ctrl[CTL_EXT_IRQ0_FLAG]};

		// ****************************************
		// APB slave
		// ****************************************
		setup = apb_req.psel && !apb_req.penable;
		wr = apb_req.psel && apb_req.penable && st_r.ready && apb_req.pwrite;
		sel = reg_sel(apb_req.paddr);
		wr_lane = wr && apb_req.pstrb[0];
		wd = apb_req.pwdata[7:0];

		st_nxt.ready = setup;
		if (setup) begin
			st_nxt.slverr = (sel == SEL_NONE);
			st_nxt.rdata = 32'h00000000;
			case (sel)
				3'h0: st_nxt.rdata[7:0] = st_r.ctrl;
				3'h1: st_nxt.rdata[7:0] = st_r.mode;
				3'h2: st_nxt.rdata[7:0] = st_r.tl0;
				3'h3: st_nxt.rdata[7:0] = st_r.th0;
				3'h4: st_nxt.rdata[7:0] = st_r.tl1;
				3'h5: st_nxt.rdata[7:0] = st_r.th1;
				3'h6: st_nxt.rdata[3:0] = apb_req.paddr[2] ? st_r.irq_mask : st_r.irq_stat;
				default: st_nxt.rdata = 32'h00000000;
			endcase
		end else begin
			// The response fields stand only in the access cycle, alongside pready.
			st_nxt.slverr = 1'b0;
			st_nxt.rdata = 32'h00000000;
		end

		// Software writes win over counting; a control write keeps hardware sets.
		st_nxt.ctrl = st_r.ctrl;
		if (wr_lane) begin
			case (sel)
				3'h0: st_nxt.ctrl = wd;
				3'h1: st_nxt.mode = wd;
				3'h2: st_nxt.tl0 = wd;
				3'h3: st_nxt.th0 = wd;
				3'h4: st_nxt.tl1 = wd;
				3'h5: st_nxt.th1 = wd;
				3'h6: begin
					if (apb_req.paddr[2]) begin
						st_nxt.irq_mask = wd[3:0];
					end
				end
				default: st_nxt.mode = st_r.mode;
			endcase
		end
		st_nxt.ctrl = (st_nxt.ctrl & ~hw_clr) | hw_set;

		// Sticky status, write one to clear; a new event beats the clear.
		st_nxt.irq_stat = st_r.irq_stat;
		if (wr_lane && sel == 3'h6 && !apb_req.paddr[2]) begin
			st_nxt.irq_stat = st_r.irq_stat & ~wd[3:0];
		end
		st_nxt.irq_stat = st_nxt.irq_stat | evt;
		st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.ctrl <= TIMER_CONTROL_RESET;
			st_r.mode <= TIMER_MODE_RESET;
			st_r.tl0 <= COUNT_RESET;
			st_r.th0 <= COUNT_RESET;
			st_r.tl1 <= COUNT_RESET;
			st_r.th1 <= COUNT_RESET;
			st_r.irq_mask <= IRQ_MASK_RESET;
			st_r.sync1 <= 4'hf;
			st_r.sync2 <= 4'hf;
			st_r.ext_prev <= 2'h3;
			st_r.pin_prev <= 2'h3;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// Outputs, all straight from the state register
	// ****************************************
	assign apb_rsp.prdata = st_r.rdata;
	assign apb_rsp.pready = st_r.ready;
	assign apb_rsp.pslverr = st_r.slverr;
	assign irq_req.timer1_overflow = st_r.ctrl[CTL_TIMER1_OVERFLOW_FLAG];
	assign irq_req.timer0_overflow = st_r.ctrl[CTL_TIMER0_OVERFLOW_FLAG];
	assign irq_req.ext_irq1 = st_r.ctrl[CTL_EXT_IRQ1_FLAG];
	assign irq_req.ext_irq0 = st_r.ctrl[CTL_EXT_IRQ0_FLAG];
	assign irq = st_r.irq;

endmodule : dual_timer_counter_control

`default_nettype wire

// File: rtl/timer_ctrl_pkg.sv
// Package with register map, field positions, reset values and carrier types of the dual timer block.
package timer_ctrl_pkg;

	// ****************************************
	// Register indices and byte addresses
	// ****************************************
	localparam int ADDR_W = 12;
	localparam logic [7:0] IDX_TIMER_CONTROL = 8'h88;
	localparam logic [7:0] IDX_TIMER_MODE = 8'h89;
	localparam logic [7:0] IDX_TIMER0_COUNT_LOW = 8'h8a;
	localparam logic [7:0] IDX_TIMER0_COUNT_HIGH = 8'h8b;
	localparam logic [7:0] IDX_TIMER1_COUNT_LOW = 8'h8c;
	localparam logic [7:0] IDX_TIMER1_COUNT_HIGH = 8'h8d;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h8e;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h8f;

	// ****************************************
	// Control register fields
	// ****************************************
	localparam int CTL_TIMER1_OVERFLOW_FLAG = 7;
	localparam int CTL_TIMER1_RUN = 6;
	localparam int CTL_TIMER0_OVERFLOW_FLAG = 5;
	localparam int CTL_TIMER0_RUN = 4;
	localparam int CTL_EXT_IRQ1_FLAG = 3;
	localparam int CTL_EXT_IRQ1_EDGE_SEL = 2;
	localparam int CTL_EXT_IRQ0_FLAG = 1;
	localparam int CTL_EXT_IRQ0_EDGE_SEL = 0;

	// ****************************************
	// Mode register fields
	// ****************************************
	localparam int MOD_TIMER1_PIN_GATING = 7;
	localparam int MOD_TIMER1_COUNT_SOURCE_SEL = 6;
	localparam int MOD_TIMER1_MODE_HI = 5;
	localparam int MOD_TIMER1_MODE_LO = 4;
	localparam int MOD_TIMER0_PIN_GATING = 3;
	localparam int MOD_TIMER0_COUNT_SOURCE_SEL = 2;
	localparam int MOD_TIMER0_MODE_HI = 1;
	localparam int MOD_TIMER0_MODE_LO = 0;

	// ****************************************
	// Interrupt status bits (same layout in the mask)
	// ****************************************
	localparam int IRQ_EXT0 = 0;
	localparam int IRQ_EXT1 = 1;
	localparam int IRQ_TIMER0 = 2;
	localparam int IRQ_TIMER1 = 3;

	// ****************************************
	// Reset values and counts
	// ****************************************
	localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
	localparam logic [7:0] TIMER_MODE_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
	localparam int PERIPH_DIV = 12;
	localparam logic [4:0] PRESCALE_LAST = 5'h1f;

	typedef enum logic [1:0] {
		MODE_PRESCALED = 2'b00,
		MODE_16BIT = 2'b01,
		MODE_AUTO_RELOAD = 2'b10,
		MODE_SPLIT_HALT = 2'b11
	} timer_mode_t;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [ADDR_W-1:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

	// Order: {ext_irq1_n, ext_irq0_n, timer1_count_pin, timer0_count_pin}.
	typedef struct packed {
		logic ext_irq1_n;
		logic ext_irq0_n;
		logic timer1_count_pin;
		logic timer0_count_pin;
	} ext_pins_t;

	// Requests and acknowledges share this layout.
	typedef struct packed {
		logic timer1_overflow;
		logic timer0_overflow;
		logic ext_irq1;
		logic ext_irq0;
	} irq_lines_t;

endpackage : timer_ctrl_pkg

// File: testbench/ext_pin_source.sv
// Model of the outside world driving the count and interrupt pins.
`timescale 1ns/10ps
`default_nettype none

module ext_pin_source
	import timer_ctrl_pkg::*;
(
	// Clock
	input wire logic pclk,
	// Requests from the bench
	input wire logic [1:0] irq_lvl_n,
	input wire logic [1:0] go,
	// Pins
	output ext_pins_t pins
);
	// ****************************************
	// Count pulses
	// ****************************************
	// Bursts start only at phase zero, so no level is ever cut short.
	logic [5:0] ph = 6'h00;
	logic [1:0] g = 2'b00;
	always @(posedge pclk) begin
		ph <= (ph == 6'd47) ? 6'h00 : ph + 6'h01;
		if (ph == 6'h00) begin
			g <= go;
		end
	end
	assign pins.timer0_count_pin = !(g[0] && ph >= 6'd24);
	assign pins.timer1_count_pin = !(g[1] && ph >= 6'd24);
	assign pins.ext_irq1_n = irq_lvl_n[1];
	assign pins.ext_irq0_n = irq_lvl_n[0];
endmodule : ext_pin_source

`default_nettype wire

// File: testbench/test_dual_timer_counter_control.sv
// Self-checking bench for the dual timer block.
`timescale 1ns/10ps
`default_nettype none

module test_dual_timer_counter_control;
	import timer_ctrl_pkg::*;
	localparam logic [7:0] CT = IDX_TIMER_CONTROL;
	localparam logic [7:0] MD = IDX_TIMER_MODE;
	localparam logic [7:0] L0 = IDX_TIMER0_COUNT_LOW;
	localparam logic [7:0] H0 = IDX_TIMER0_COUNT_HIGH;
	localparam logic [7:0] L1 = IDX_TIMER1_COUNT_LOW;
	localparam logic [7:0] H1 = IDX_TIMER1_COUNT_HIGH;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	apb_req_t rq = '0;
	apb_rsp_t rs;
	ext_pins_t pins;
	irq_lines_t ak = '0;
	irq_lines_t rqo;
	logic irq;
	logic [1:0] lvl_n = 2'b11;
	logic [1:0] go = 2'b00;
	logic [7:0] q;
	logic e;
	int n_mismatch = 0;
	int checks_done = 0;

	always #10 pclk = !pclk;

	dual_timer_counter_control dual_timer_counter_control_i (.pclk(pclk), .presetn(presetn),
		.apb_req(rq), .apb_rsp(rs), .pins(pins), .irq_ack(ak), .irq_req(rqo), .irq(irq));
	ext_pin_source ext_pin_source_i (.pclk(pclk), .irq_lvl_n(lvl_n), .go(go), .pins(pins));

	// ****************************************
	// Bus and check helpers
	// ****************************************
	task wt(input int k);
		repeat (k) @(posedge pclk);
	endtask : wt

	task chk(input string s, input logic [7:0] x, input logic [7:0] g);
		checks_done++;
		if (g !== x) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", s, x, g);
		end
	endtask : chk

	task xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
		rq.paddr <= a;
		rq.pwrite <= w;
		rq.pwdata <= {24'h0, d};
		rq.pstrb <= 4'hf;
		rq.psel <= 1'b1;
		@(posedge pclk);
		rq.penable <= 1'b1;
		// Waits as long as the slave stretches the access; only the watchdog ends a hang.
		do begin
			@(posedge pclk);
		end while (rs.pready !== 1'b1);
		q = rs.prdata[7:0];
		e = rs.pslverr;
		rq.psel <= 1'b0;
		rq.penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer

	task wr(input logic [7:0] i, input logic [7:0] d);
		xfer({2'b00, i, 2'b00}, 1'b1, d);
	endtask : wr

	task rc(input logic [7:0] i, input logic [7:0] x);
		xfer({2'b00, i, 2'b00}, 1'b0, 8'h00);
		chk($sformatf("reg %h", i), x, q);
	endtask : rc

	task pulse_ack(input irq_lines_t a);
		ak <= a;
		@(posedge pclk);
		ak <= '0;
		@(posedge pclk);
	endtask : pulse_ack

	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset;
		rc(CT, 8'h00);
		rc(MD, 8'h00);
		xfer(12'h221, 1'b1, 8'hff);
		chk("pslverr", 8'h01, {7'h0, e});
		rc(CT, 8'h00);
		$display("test reset done");
	endtask : t_reset

	task t_rate;
		wr(MD, 8'h01);
		wr(CT, 8'h10);
		wt(237);
		wr(CT, 8'h00);
		rc(L0, 8'd20);
		wt(30);
		rc(L0, 8'd20);
		$display("test rate done");
	endtask : t_rate

	task t_overflow;
		wr(L0, 8'hff);
		wr(H0, 8'hff);
		wr(CT, 8'h10);
		wt(20);
		rc(CT, 8'h30);
		rc(H0, 8'h00);
		wr(CT, 8'h20);
		chk("irq_req", 8'h04, {4'h0, rqo});
		rc(IDX_IRQ_STATUS, 8'h04);
		chk("irq", 8'h00, {7'h0, irq});
		wr(IDX_IRQ_MASK, 8'h04);
		wt(2);
		chk("irq", 8'h01, {7'h0, irq});
		wr(IDX_IRQ_STATUS, 8'h04);
		wt(2);
		chk("irq", 8'h00, {7'h0, irq});
		pulse_ack(4'b0100);
		rc(CT, 8'h00);
		$display("test overflow done");
	endtask : t_overflow

	task t_reload;
		wr(H0, 8'hfc);
		wr(L0, 8'hfe);
		wr(MD, 8'h02);
		wr(CT, 8'h10);
		wt(35);
		rc(CT, 8'h30);
		wt(19);
		wr(CT, 8'h20);
		rc(L0, 8'hff);
		rc(H0, 8'hfc);
		wr(CT, 8'h00);
		$display("test reload done");
	endtask : t_reload

	task t_prescale_halt;
		wr(MD, 8'h00);
		wr(L1, 8'hfe);
		wr(H1, 8'hff);
		wr(CT, 8'h40);
		wt(21);
		wr(MD, 8'h30);
		rc(L1, 8'he0);
		rc(H1, 8'h00);
		rc(CT, 8'hc0);
		wt(50);
		rc(L1, 8'he0);
		wr(CT, 8'h00);
		$display("test prescale done");
	endtask : t_prescale_halt

	task t_split;
		wr(MD, 8'h03);
		wr(L0, 8'h00);
		wr(H0, 8'hff);
		wr(CT, 8'h40);
		wt(21);
		wr(MD, 8'h00);
		rc(CT, 8'hc0);
		rc(H0, 8'h01);
		rc(L0, 8'h00);
		wr(CT, 8'h00);
		$display("test split done");
	endtask : t_split

	task t_counter;
		int nf;
		logic pv;
		wr(L0, 8'h00);
		wr(MD, 8'h0d);
		lvl_n[0] <= 1'b0;
		wr(CT, 8'h10);
		go[0] <= 1'b1;
		wt(200);
		go[0] <= 1'b0;
		wt(60);
		rc(L0, 8'h00);
		lvl_n[0] <= 1'b1;
		wt(10);
		go[0] <= 1'b1;
		nf = 0;
		pv = 1'b1;
		for (int k = 0; k < 400; k++) begin
			if (k == 300) begin
				go[0] <= 1'b0;
			end
			@(posedge pclk);
			if (pv && !pins.timer0_count_pin) begin
				nf++;
			end
			pv = pins.timer0_count_pin;
		end
		wr(CT, 8'h00);
		rc(L0, nf[7:0]);
		$display("test counter done");
	endtask : t_counter

	task t_ext;
		wr(CT, 8'h01);
		lvl_n[0] <= 1'b0;
		wt(6);
		lvl_n[0] <= 1'b1;
		wt(6);
		rc(CT, 8'h03);
		pulse_ack(4'b0001);
		chk("irq_req", 8'h00, {4'h0, rqo});
		lvl_n[1] <= 1'b0;
		wt(6);
		pulse_ack(4'b0010);
		rc(CT, 8'h09);
		lvl_n[1] <= 1'b1;
		wt(6);
		rc(CT, 8'h01);
		$display("test ext done");
	endtask : t_ext

	task t_sw_write;
		wr(CT, 8'ha5);
		rc(CT, 8'ha5);
		chk("irq_req", 8'h0c, {4'h0, rqo});
		pulse_ack(4'b1000);
		chk("irq_req", 8'h04, {4'h0, rqo});
		wr(CT, 8'h00);
		rc(CT, 8'h00);
		$display("test write done");
	endtask : t_sw_write

	task test_done;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done

	initial begin
		wt(3);
		presetn <= 1'b1;
		wt(1);
		t_reset();
		t_rate();
		t_overflow();
		t_reload();
		t_prescale_halt();
		t_split();
		t_counter();
		t_ext();
		t_sw_write();
		test_done();
	end

	initial begin
		wt(20000);
		n_mismatch++;
		test_done();
	end
endmodule : test_dual_timer_counter_control

`default_nettype wire

// File: testbench/timer_ctrl_assertions.sv
// Checker for the port behaviour of the dual timer block, bound to its top module.
`timescale 1ns/10ps
`default_nettype none

module timer_ctrl_assertions
	import timer_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus and pins
	input wire apb_req_t apb_req,
	input wire apb_rsp_t apb_rsp,
	input wire ext_pins_t pins,
	// Interrupt side
	input wire irq_lines_t irq_ack,
	input wire irq_lines_t irq_req,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ****************************************
	// Control register write at its commit edge
	// ****************************************
	logic wctl;
	assign wctl = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready
		&& apb_req.pstrb[0] && apb_req.paddr == {2'b00, IDX_TIMER_CONTROL, 2'b00};

	a_ready_after_setup: assert property (apb_req.psel && !apb_req.penable |-> ##1 apb_rsp.pready)
		else $error("pready missing after setup");
	a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready held too long");
	a_err_misaligned: assert property (apb_req.psel && !apb_req.penable && apb_req.paddr[1:0] != 2'b00
		|=> apb_rsp.pslverr) else $error("misaligned access not refused");
	a_err_with_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
		else $error("pslverr without pready");
	a_rdata_upper_zero: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_ack_clears_t0: assert property (irq_ack.timer0_overflow && !wctl |=> !irq_req.timer0_overflow)
		else $error("timer0 flag kept after acknowledge");
	a_ack_clears_t1: assert property (irq_ack.timer1_overflow && !wctl |=> !irq_req.timer1_overflow)
		else $error("timer1 flag kept after acknowledge");
	a_flag0_sticks: assert property (irq_req.timer0_overflow && !irq_ack.timer0_overflow && !wctl
		|=> irq_req.timer0_overflow) else $error("timer0 flag dropped by itself");
	a_flag1_sticks: assert property (irq_req.timer1_overflow && !irq_ack.timer1_overflow && !wctl
		|=> $stable(irq_req.timer1_overflow)) else $error("timer1 flag dropped by itself");
	a_write_sets_flag: assert property (wctl && apb_req.pwdata[7] && !irq_ack.timer1_overflow
		|=> irq_req.timer1_overflow) else $error("control write did not set flag");

	c_error: cover property (apb_rsp.pslverr);
	c_irq: cover property ($rose(irq));
	c_ack: cover property (irq_ack.ext_irq0 ##1 !irq_req.ext_irq0);
endmodule : timer_ctrl_assertions

bind dual_timer_counter_control timer_ctrl_assertions timer_ctrl_assertions_i (
	.pclk(pclk),
	.presetn(presetn),
	.apb_req(apb_req),
	.apb_rsp(apb_rsp),
	.pins(pins),
	.irq_ack(irq_ack),
	.irq_req(irq_req),
	.irq(irq)
);

`default_nettype wire
